// File: verilog/srsc_top.sv
`timescale 1ns/10ps

// Notes on behaviour
// - all six sources merge into one master reset output for the chip.
// - configuration mismatch reset or a software write sets cause flag bit 9.
// - external clear pin reset sets pin cause flag bit 7.
// - an executed software reset sets software cause flag bit 6.
// - watchdog time-out sets watchdog flag bit 4.
// - wake or reset while in Sleep sets flag bit 3.
// - wake or reset while in Idle sets flag bit 2.
// - brown-out sets flag bit 1; reads one after power-on.
// - power-on sets flag bit 0; reads one after power-on.
// - power-on and brown-out flags stay set until software writes zero.
// - bit 8 one keeps regulator on in Sleep, zero selects standby.
// - control register bits 31..10 and 5 read zero, ignore writes.
// - writing one to trigger bit 0 raises a software reset event.
// - trigger bit is write-only, resets to zero, clears itself.
// - trigger write is accepted only after the unlock sequence.
// - clear, set, invert aliases at +0x4, +0x8, +0xC act per one bit.
// - trigger register bits 31..1 read zero and ignore writes.
// - reset values follow reset type and non-volatile config words.
module srsc_top
  import srsc_pkg::*;
(
  // clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RESET,
  // reset sources
  input  wire logic              POWER_ON_DET,
  input  wire logic              BROWNOUT_DET,
  input  wire logic              CLEAR_PIN_N,
  input  wire logic              WATCHDOG_TIMEOUT,
  input  wire logic              CONFIG_MISMATCH,
  // power mode and system state
  input  wire logic              SLEEP_MODE,
  input  wire logic              IDLE_MODE,
  input  wire logic              WAKE_EVENT,
  input  wire logic              UNLOCKED,
  input  wire logic              CFG_REGEN_DEFAULT,
  // outputs
  output wire logic              SYSTEM_MASTER_RESET,
  output wire logic              REGULATOR_SLEEP_ENABLE,
  // axi4-lite write address
  input  wire logic              AWVALID,
  output wire logic              AWREADY,
  input  wire logic [AXI_AW-1:0] AWADDR,
  // axi4-lite write data
  input  wire logic              WVALID,
  output wire logic              WREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  // axi4-lite write response
  output wire logic              BVALID,
  input  wire logic              BREADY,
  output wire logic [1:0]        BRESP,
  // axi4-lite read address
  input  wire logic              ARVALID,
  output wire logic              ARREADY,
  input  wire logic [AXI_AW-1:0] ARADDR,
  // axi4-lite read data
  output wire logic              RVALID,
  input  wire logic              RREADY,
  output wire logic [31:0]       RDATA,
  output wire logic [1:0]        RRESP
);

  localparam int HOLD_W = $clog2(STRETCH_CYC + 1);
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(STRETCH_CYC);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0]        pin_s;
    logic              pin_q;
    logic [NSRC-1:0]   lvl_q;
    logic [CTL_W-1:0]  ctl_q;
    logic              trig_q;
    logic [HOLD_W-1:0] hold_q;
    logic              init_q;
    logic              mrst_q;
    logic              aw_q;
    logic [AXI_AW-1:0] awaddr_q;
    logic              w_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;
  } srsc_state_t;

  srsc_state_t st_q;
  srsc_state_t st_d;

  // ------------------------------------------------------------
  // alias write helper
  // ------------------------------------------------------------
  function automatic logic [31:0] srsc_alias(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [31:0] bm,
    input logic [1:0]  sel
  );
    logic [31:0] m;
    m = wd & bm;
    unique case (sel)
      ALIAS_BASE: srsc_alias = (old & ~bm) | m;
      ALIAS_CLR:  srsc_alias = old & ~m;
      ALIAS_SET:  srsc_alias = old | m;
      ALIAS_INV:  srsc_alias = old ^ m;
    endcase
  endfunction : srsc_alias

  // ------------------------------------------------------------
  // decode and source edges
  // ------------------------------------------------------------
  logic [NSRC-1:0] src;
  logic [NSRC-1:0] rise;
  logic            any_evt;
  logic            aw_rdy;
  logic            w_rdy;
  logic            ar_rdy;
  logic            wr_go;
  logic            wr_ctl;
  logic            wr_swt;
  logic [1:0]      wr_sel;
  logic [31:0]     bm;
  logic [31:0]     ctl_wr;
  logic [31:0]     swt_wr;
  logic            swt_one;
  logic            rd_ctl;
  logic            rd_swt;

  assign src[S_POR] = POWER_ON_DET;
  assign src[S_BROWN] = BROWNOUT_DET;
  assign src[S_WDT] = WATCHDOG_TIMEOUT;
  assign src[S_MISM] = CONFIG_MISMATCH;
  assign src[S_PIN] = st_q.pin_q;
  // only a fresh assertion marks a cause, so a long source sets once
  assign rise    = src & ~st_q.lvl_q;
  assign any_evt = (|rise) | st_q.trig_q;

  assign aw_rdy  = !st_q.aw_q && !st_q.bvalid_q;
  assign w_rdy   = !st_q.w_q && !st_q.bvalid_q;
  assign ar_rdy  = !st_q.rvalid_q;
  assign wr_go   = st_q.aw_q && st_q.w_q && !st_q.bvalid_q;
  assign wr_sel  = st_q.awaddr_q[3:2];
  assign wr_ctl  = st_q.awaddr_q[15:4] == CTL_OFS[15:4];
  assign wr_swt  = st_q.awaddr_q[15:4] == SWT_OFS[15:4];
  assign rd_ctl  = ARADDR[15:4] == CTL_OFS[15:4];
  assign rd_swt  = ARADDR[15:4] == SWT_OFS[15:4];
  assign bm      = {{8{st_q.wstrb_q[3]}}, {8{st_q.wstrb_q[2]}},
                    {8{st_q.wstrb_q[1]}}, {8{st_q.wstrb_q[0]}}};
  // aliases act on the stored value; the trigger always reads as zero
  assign ctl_wr  = srsc_alias({22'h0, st_q.ctl_q}, st_q.wdata_q, bm,
                              wr_sel);
  assign swt_wr  = srsc_alias(32'h0, st_q.wdata_q, bm, wr_sel);
  assign swt_one = swt_wr[B_TRIG];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [CTL_W-1:0] hw;
    logic [CTL_W-1:0] rc;
    hw = '0;
    rc = st_q.ctl_q;
    st_d = st_q;

    // pin filter: level moves only when the last two stages agree
    st_d.pin_s = {st_q.pin_s[1:0], ~CLEAR_PIN_N};
    if (st_q.pin_s[2] == st_q.pin_s[1]) begin
      st_d.pin_q = st_q.pin_s[2];
    end
    st_d.lvl_q = src;

    // write channel: address and data taken in either order
    if (AWVALID && aw_rdy) begin
      st_d.aw_q     = 1'b1;
      st_d.awaddr_q = AWADDR;
    end
    if (WVALID && w_rdy) begin
      st_d.w_q     = 1'b1;
      st_d.wdata_q = WDATA;
      st_d.wstrb_q = WSTRB;
    end
    if (wr_go) begin
      st_d.aw_q     = 1'b0;
      st_d.w_q      = 1'b0;
      st_d.bvalid_q = 1'b1;
      st_d.bresp_q  = (wr_ctl || wr_swt) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_q.bvalid_q && BREADY) begin
      st_d.bvalid_q = 1'b0;
    end

    // read channel
    if (ARVALID && ar_rdy) begin
      st_d.rvalid_q = 1'b1;
      st_d.rresp_q  = RESP_OKAY;
      st_d.rdata_q  = 32'h0;
      if (rd_ctl) begin
        st_d.rdata_q = {22'h0, st_q.ctl_q & CTL_WMASK};
      end else if (!rd_swt) begin
        st_d.rresp_q = RESP_SLVERR;
      end
    end else if (st_q.rvalid_q && RREADY) begin
      st_d.rvalid_q = 1'b0;
    end

    // software side of the control register
    if (wr_go && wr_ctl) begin
      rc = ctl_wr[CTL_W-1:0] & CTL_WMASK;
    end
    // regulator default comes from the config word at reset release
    if (st_q.init_q) begin
      rc[B_REGEN] = CFG_REGEN_DEFAULT;
      st_d.init_q = 1'b0;
    end

    // hardware sets are ored last so an event beats a clear
    hw[B_POR]   = rise[S_POR];
    hw[B_BROWN] = rise[S_BROWN];
    hw[B_WDOG]  = rise[S_WDT];
    hw[B_MISM]  = rise[S_MISM];
    hw[B_PIN]   = rise[S_PIN];
    hw[B_SOFT]  = st_q.trig_q;
    hw[B_SLEEP] = (WAKE_EVENT || any_evt) && SLEEP_MODE;
    hw[B_IDLE]  = (WAKE_EVENT || any_evt) && IDLE_MODE;
    st_d.ctl_q  = rc | hw;

    // trigger is a one-cycle pulse, honoured only when unlocked
    st_d.trig_q = wr_go && wr_swt && swt_one && UNLOCKED;
    if (st_q.trig_q) begin
      st_d.hold_q = HOLD_LOAD;
    end else if (st_q.hold_q != '0) begin
      st_d.hold_q = st_q.hold_q - 1'b1;
    end

    // software reset is stretched so the whole chip sees a clean pulse
    st_d.mrst_q = (|src) || st_q.trig_q || (st_q.hold_q != '0);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // only the power-on reset clears this block; the master reset it
  // drives does not, so cause flags survive for software to read
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      st_q        <= '0;
      st_q.ctl_q  <= CTL_POR_VAL;
      st_q.init_q <= 1'b1;
      st_q.mrst_q <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign SYSTEM_MASTER_RESET    = st_q.mrst_q;
  assign REGULATOR_SLEEP_ENABLE = st_q.ctl_q[B_REGEN];
  assign AWREADY = aw_rdy;
  assign WREADY  = w_rdy;
  assign BVALID  = st_q.bvalid_q;
  assign BRESP   = st_q.bresp_q;
  assign ARREADY = ar_rdy;
  assign RVALID  = st_q.rvalid_q;
  assign RDATA   = st_q.rdata_q;
  assign RRESP   = st_q.rresp_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  property p_merge;
    (|src) |=> SYSTEM_MASTER_RESET;
  endproperty
  a_merge: assert property (p_merge)
    else $error("source active but master reset low");

  property p_stretch;
    $rose(st_q.trig_q) |=> SYSTEM_MASTER_RESET [*8];
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("software reset not stretched");

  property p_mism;
    rise[S_MISM] |=> st_q.ctl_q[B_MISM];
  endproperty
  a_mism: assert property (p_mism)
    else $error("mismatch flag not set");

  property p_mism_only;
    !rise[S_MISM] && !(wr_go && wr_ctl)
      |=> st_q.ctl_q[B_MISM] == $past(st_q.ctl_q[B_MISM]);
  endproperty
  a_mism_only: assert property (p_mism_only)
    else $error("mismatch flag changed without cause");

  property p_pin;
    !CLEAR_PIN_N [*5] |-> ##[1:2] st_q.ctl_q[B_PIN];
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin flag not set after clear pin");

  property p_soft;
    st_q.trig_q |=> st_q.ctl_q[B_SOFT] && SYSTEM_MASTER_RESET;
  endproperty
  a_soft: assert property (p_soft)
    else $error("software flag or reset missing");

  property p_wdt;
    $rose(WATCHDOG_TIMEOUT) |=> st_q.ctl_q[B_WDOG];
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog flag not set");

  property p_sleep;
    WAKE_EVENT && SLEEP_MODE |=> st_q.ctl_q[B_SLEEP];
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep flag not set");

  property p_idle;
    WAKE_EVENT && IDLE_MODE |=> st_q.ctl_q[B_IDLE];
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle flag not set");

  property p_brown;
    $rose(BROWNOUT_DET) |=> st_q.ctl_q[B_BROWN];
  endproperty
  a_brown: assert property (p_brown)
    else $error("brown-out flag not set");

  property p_por;
    $rose(POWER_ON_DET) |=> st_q.ctl_q[B_POR];
  endproperty
  a_por: assert property (p_por)
    else $error("power-on flag not set");

  property p_sticky;
    st_q.ctl_q[B_POR] && !(wr_go && wr_ctl) |=> st_q.ctl_q[B_POR];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("power-on flag fell without a write");

  property p_vreg;
    wr_go && wr_ctl && wr_sel == ALIAS_SET && st_q.wdata_q[B_REGEN]
      && st_q.wstrb_q[1] |=> ##1 REGULATOR_SLEEP_ENABLE;
  endproperty
  a_vreg: assert property (p_vreg)
    else $error("regulator enable not set");

  property p_clr;
    wr_go && wr_ctl && wr_sel == ALIAS_CLR && st_q.wdata_q[B_REGEN]
      && st_q.wstrb_q[1] |=> !st_q.ctl_q[B_REGEN];
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear alias did not clear");

  property p_rsv;
    RVALID |-> RDATA[31:10] == 22'h0 && !RDATA[5];
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bits read nonzero");

  property p_trig;
    wr_go && wr_swt && swt_one && UNLOCKED |=> st_q.trig_q;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger not taken");

  property p_hc;
    st_q.trig_q |=> !st_q.trig_q;
  endproperty
  a_hc: assert property (p_hc)
    else $error("trigger not cleared");

  property p_lock;
    wr_go && wr_swt && !UNLOCKED |=> !st_q.trig_q;
  endproperty
  a_lock: assert property (p_lock)
    else $error("trigger taken while locked");

  property p_cfg;
    $fell(st_q.init_q) |-> REGULATOR_SLEEP_ENABLE == $past(CFG_REGEN_DEFAULT);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("regulator default not from config");

endmodule : srsc_top

// File: include/srsc_pkg.sv
package srsc_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, low 16 bits decoded)
  // ------------------------------------------------------------
  localparam int          AXI_AW       = 16;
  localparam logic [15:0] CTL_OFS      = 16'hf600;
  localparam logic [15:0] SWT_OFS      = 16'hf610;
  localparam logic [1:0]  ALIAS_BASE   = 2'h0;
  localparam logic [1:0]  ALIAS_CLR    = 2'h1;
  localparam logic [1:0]  ALIAS_SET    = 2'h2;
  localparam logic [1:0]  ALIAS_INV    = 2'h3;

  // ------------------------------------------------------------
  // reset_cause_control fields
  // ------------------------------------------------------------
  localparam int          CTL_W        = 10;
  localparam int          B_POR        = 0;
  localparam int          B_BROWN      = 1;
  localparam int          B_IDLE       = 2;
  localparam int          B_SLEEP      = 3;
  localparam int          B_WDOG       = 4;
  localparam int          B_SOFT       = 6;
  localparam int          B_PIN        = 7;
  localparam int          B_REGEN      = 8;
  localparam int          B_MISM       = 9;
  localparam logic [9:0]  CTL_WMASK    = 10'h3df;
  localparam logic [9:0]  CTL_POR_VAL  = 10'h003;
  localparam int          B_TRIG       = 0;

  // ------------------------------------------------------------
  // reset source indices
  // ------------------------------------------------------------
  localparam int          NSRC         = 5;
  localparam int          S_POR        = 0;
  localparam int          S_BROWN      = 1;
  localparam int          S_WDT        = 2;
  localparam int          S_MISM       = 3;
  localparam int          S_PIN        = 4;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int          CLK_NS       = 4;
  localparam int          STRETCH_NS   = 100;
  localparam int          STRETCH_CYC  = (STRETCH_NS + CLK_NS - 1) / CLK_NS;

  // ------------------------------------------------------------
  // bus responses
  // ------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage : srsc_pkg

// File: sim/srsc_top_bench.sv
`timescale 1ns/10ps
module srsc_top_bench import srsc_pkg::*;;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic              CLOCK, RESET, POWER_ON_DET, BROWNOUT_DET;
  logic              CLEAR_PIN_N, WATCHDOG_TIMEOUT, CONFIG_MISMATCH;
  logic              SLEEP_MODE, IDLE_MODE, WAKE_EVENT, UNLOCKED;
  logic              CFG_REGEN_DEFAULT, SYSTEM_MASTER_RESET;
  logic              REGULATOR_SLEEP_ENABLE, AWVALID, AWREADY, WVALID;
  logic              WREADY, BVALID, BREADY, ARVALID, ARREADY;
  logic              RVALID, RREADY;
  logic [AXI_AW-1:0] AWADDR, ARADDR;
  logic [31:0]       WDATA, RDATA, d;
  logic [3:0]        WSTRB;
  logic [1:0]        BRESP, RRESP, r;
  logic [9:0]        ctl_exp;
  logic              seen;
  int                n_fail, checks, n;
  localparam logic [15:0] CTL_A = 16'hf600;
  localparam logic [15:0] TRG_A = 16'hf610;
  localparam logic [15:0] BAD_A = 16'h0040;

  srsc_top u_srsc_top (.CLOCK(CLOCK), .RESET(RESET),
    .POWER_ON_DET(POWER_ON_DET), .BROWNOUT_DET(BROWNOUT_DET),
    .CLEAR_PIN_N(CLEAR_PIN_N), .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT),
    .CONFIG_MISMATCH(CONFIG_MISMATCH), .SLEEP_MODE(SLEEP_MODE),
    .IDLE_MODE(IDLE_MODE), .WAKE_EVENT(WAKE_EVENT), .UNLOCKED(UNLOCKED),
    .CFG_REGEN_DEFAULT(CFG_REGEN_DEFAULT),
    .SYSTEM_MASTER_RESET(SYSTEM_MASTER_RESET),
    .REGULATOR_SLEEP_ENABLE(REGULATOR_SLEEP_ENABLE),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP));

  always #2 CLOCK = ~CLOCK;

  // ------------------------------------------------------------
  // expectation model and compares
  // ------------------------------------------------------------
  function automatic logic [9:0] f_after(logic [9:0] old, logic [31:0] wd,
                                         logic [3:0] s, logic [1:0] sel);
    logic [9:0] m;
    m = wd[9:0] & {{2{s[1]}}, {8{s[0]}}} & 10'h3df;
    case (sel)
      2'h0: f_after = (old & ~({{2{s[1]}}, {8{s[0]}}} & 10'h3df)) | m;
      2'h1: f_after = old & ~m;
      2'h2: f_after = old | m;
      default: f_after = old ^ m;
    endcase
  endfunction : f_after

  task automatic chk32(string what, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk32

  task automatic chk1(string what, logic e, logic g);
    chk32(what, {31'h0, e}, {31'h0, g});
  endtask : chk1

  task automatic chk2(string what, logic [1:0] e, logic [1:0] g);
    chk32(what, {30'h0, e}, {30'h0, g});
  endtask : chk2

  task automatic tick(int k);
    repeat (k) @(posedge CLOCK);
  endtask : tick

  // ------------------------------------------------------------
  // axi4-lite master: holds each channel until its own ready
  // ------------------------------------------------------------
  task automatic axi_write(logic [15:0] a, logic [31:0] wd, logic [3:0] s,
                           output logic [1:0] rs);
    bit aw;
    bit w;
    int k;
    aw = 0;
    w = 0;
    k = 0;
    @(posedge CLOCK);
    AWVALID <= 1'b1;
    AWADDR <= a;
    WVALID <= 1'b1;
    WDATA <= wd;
    WSTRB <= s;
    BREADY <= 1'b1;
    while (!(aw && w) && k < 100) begin
      @(posedge CLOCK);
      k++;
      if (!aw && AWREADY === 1'b1) begin
        aw = 1;
        AWVALID <= 1'b0;
      end
      if (!w && WREADY === 1'b1) begin
        w = 1;
        WVALID <= 1'b0;
      end
    end
    do begin
      @(posedge CLOCK);
      k++;
    end while (BVALID !== 1'b1 && k < 200);
    if (k >= 200) n_fail++;
    rs = BRESP;
    BREADY <= 1'b0;
    if (a[15:4] == CTL_A[15:4]) ctl_exp = f_after(ctl_exp, wd, s, a[3:2]);
  endtask : axi_write

  task automatic axi_read(logic [15:0] a, output logic [31:0] rd,
                          output logic [1:0] rs);
    int k;
    k = 0;
    @(posedge CLOCK);
    ARVALID <= 1'b1;
    ARADDR <= a;
    RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      k++;
    end while (ARREADY !== 1'b1 && k < 100);
    ARVALID <= 1'b0;
    do begin
      @(posedge CLOCK);
      k++;
    end while (RVALID !== 1'b1 && k < 200);
    if (k >= 200) n_fail++;
    rd = RDATA;
    rs = RRESP;
    RREADY <= 1'b0;
  endtask : axi_read

  task automatic wr_ok(logic [15:0] a, logic [31:0] wd, logic [3:0] s);
    axi_write(a, wd, s, r);
    chk2("write response", RESP_OKAY, r);
  endtask : wr_ok

  task automatic rd_ctl(logic [15:0] a);
    axi_read(a, d, r);
    chk2("read response", RESP_OKAY, r);
    chk32("control word", {22'h0, ctl_exp}, d);
  endtask : rd_ctl

  task automatic set_src(int k, logic v);
    case (k)
      0: POWER_ON_DET <= v;
      1: BROWNOUT_DET <= v;
      2: WATCHDOG_TIMEOUT <= v;
      3: CONFIG_MISMATCH <= v;
      4: CLEAR_PIN_N <= !v;
      default: WAKE_EVENT <= v;
    endcase
  endtask : set_src

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end

  initial begin
    static int fbit [6] = '{0, 1, 4, 9, 7, -1};
    CLOCK = 0; RESET = 1; POWER_ON_DET = 0; BROWNOUT_DET = 0;
    CLEAR_PIN_N = 1; WATCHDOG_TIMEOUT = 0; CONFIG_MISMATCH = 0;
    SLEEP_MODE = 0; IDLE_MODE = 0; WAKE_EVENT = 0; UNLOCKED = 0;
    CFG_REGEN_DEFAULT = 1; AWVALID = 0; AWADDR = '0; WVALID = 0;
    WDATA = '0; WSTRB = '0; BREADY = 0; ARVALID = 0; ARADDR = '0;
    RREADY = 0; n_fail = 0; checks = 0;
    void'($urandom(32'h4f47eead));
    tick(5);
    RESET <= 1'b0;
    ctl_exp = 10'h103;
    tick(3);
    chk1("master idle", 1'b0, SYSTEM_MASTER_RESET);
    chk1("regulator", 1'b1, REGULATOR_SLEEP_ENABLE);
    rd_ctl(CTL_A);
    rd_ctl(CTL_A + 16'h4);
    $display("test reset values done");
    wr_ok(CTL_A + 16'h4, 32'hffffffff, 4'hf);
    rd_ctl(CTL_A);
    wr_ok(CTL_A + 16'h8, 32'h3ff, 4'h0);
    rd_ctl(CTL_A);
    chk1("regulator", 1'b0, REGULATOR_SLEEP_ENABLE);
    repeat (20) begin
      wr_ok(CTL_A + 16'($urandom_range(0, 3) * 4), $urandom,
            4'($urandom_range(0, 15)));
      rd_ctl(CTL_A);
      chk1("regulator", ctl_exp[8], REGULATOR_SLEEP_ENABLE);
    end
    axi_write(BAD_A, 32'h1, 4'hf, r);
    chk2("unmapped write", RESP_SLVERR, r);
    axi_read(BAD_A, d, r);
    chk2("unmapped read", RESP_SLVERR, r);
    chk32("unmapped data", 32'h0, d);
    $display("test register access done");
    for (int k = 0; k < 6; k++) begin
      wr_ok(CTL_A + 16'h4, 32'h3ff, 4'hf);
      SLEEP_MODE <= k[0];
      IDLE_MODE <= !k[0];
      tick(1);
      set_src(k, 1'b1);
      tick(k == 5 ? 1 : 10);
      if (k < 5) chk1("master held", 1'b1, SYSTEM_MASTER_RESET);
      set_src(k, 1'b0);
      tick(10);
      chk1("master released", 1'b0, SYSTEM_MASTER_RESET);
      SLEEP_MODE <= 1'b0;
      IDLE_MODE <= 1'b0;
      ctl_exp = k[0] ? 10'h008 : 10'h004;
      if (k < 5) ctl_exp[fbit[k]] = 1'b1;
      rd_ctl(CTL_A);
    end
    $display("test reset sources done");
    wr_ok(CTL_A + 16'h4, 32'h3ff, 4'hf);
    axi_write(TRG_A, 32'h1, 4'hf, r);
    chk2("locked trigger", RESP_OKAY, r);
    seen = 0;
    repeat (30) begin
      tick(1);
      seen |= SYSTEM_MASTER_RESET;
    end
    chk1("locked no reset", 1'b0, seen);
    rd_ctl(CTL_A);
    UNLOCKED <= 1'b1;
    wr_ok(TRG_A, $urandom & 32'hfffffffe, 4'hf);
    tick(5);
    chk1("zero trigger", 1'b0, SYSTEM_MASTER_RESET);
    for (int i = 0; i < 2; i++) begin
      wr_ok(i ? TRG_A + 16'h8 : TRG_A, 32'h1, 4'hf);
      n = 0;
      while (SYSTEM_MASTER_RESET !== 1'b1 && n < 5) begin
        tick(1);
        n++;
      end
      chk1("software reset", 1'b1, SYSTEM_MASTER_RESET);
      n = 0;
      while (SYSTEM_MASTER_RESET === 1'b1 && n < 100) begin
        tick(1);
        n++;
      end
      chk1("stretch", n >= STRETCH_CYC - 1 && n <= STRETCH_CYC + 2, 1'b1);
      axi_read(TRG_A, d, r);
      chk32("trigger readback", 32'h0, d);
      ctl_exp = 10'h040;
      rd_ctl(CTL_A);
      wr_ok(CTL_A + 16'h4, 32'h3ff, 4'hf);
    end
    $display("test software reset done");
    // second power-on with the config default low
    RESET <= 1'b1;
    CFG_REGEN_DEFAULT <= 1'b0;
    tick(2);
    chk1("master in reset", 1'b1, SYSTEM_MASTER_RESET);
    RESET <= 1'b0;
    ctl_exp = 10'h003;
    tick(3);
    chk1("master idle", 1'b0, SYSTEM_MASTER_RESET);
    chk1("regulator", 1'b0, REGULATOR_SLEEP_ENABLE);
    rd_ctl(CTL_A);
    $display("test second reset done");
    give_verdict();
  end
endmodule : srsc_top_bench
